// File: logic/uart_flow_cfg.svh
// Register offsets, field positions, reset values and counts
`ifndef UART_FLOW_CFG_SVH
`define UART_FLOW_CFG_SVH
// Register offsets on the plain register port
`define OFS_FEATURE    4'h0
`define OFS_ENHANCED   4'h1
`define OFS_RESUME1    4'h2
`define OFS_RESUME2    4'h3
`define OFS_PAUSE1     4'h4
`define OFS_PAUSE2     4'h5
`define OFS_TURN_DLY   4'h6
`define OFS_IRQ_EN     4'h7
`define OFS_FIFO_CTL   4'h8
`define OFS_MODEM_CTL  4'h9
`define OFS_IRQ_STAT   4'hA
`define OFS_STATE      4'hB
// Feature control fields
`define FC_HYST_LSB    0
`define FC_RX_INV      4
`define FC_AUTO485     5
`define FC_TABLE_LSB   6
// Enhanced feature control fields
`define EF_RX_LSB      0
`define EF_TX_LSB      2
`define EF_ENH         4
`define EF_SPECIAL     5
`define EF_AUTO_RTS    6
`define EF_AUTO_CTS    7
// Status bits
`define ST_SPECIAL     0
`define ST_PAUSE       1
// Reset values
`define RST_BYTE       8'h00
`define RST_NIBBLE     4'h0
// Pause is sent this many character times after the trigger
`define PAUSE_CHARS    2
`define CHAR_BITS_DEF  10
`endif

// File: logic/uart_flow_pkg.sv
// Types shared by the flow and half-duplex control block
package uart_flow_pkg;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;
   typedef struct packed {
      logic thr_load;
      logic thr_empty;
      logic tsr_empty;
      logic bit_tick;
   } tx_evt_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } rx_char_t;
   typedef enum logic [1:0] {D_RX, D_TX, D_TURN} dir_state_t;
   typedef enum logic [1:0] {F_IDLE, F_WAIT, F_SEND} flow_state_t;
endpackage : uart_flow_pkg

// File: logic/hyst_lookup.sv
// Hysteresis code to character count for trigger table D
module hyst_lookup (
   // Code in, count out
   input  wire logic [3:0] code,
   output logic      [6:0] hyst
);
   // Upper codes are not monotonic; the pattern follows the level table
   always_comb begin
      case (code)
         4'h0:    hyst = 7'h00;
         4'h1:    hyst = 7'h04;
         4'h2:    hyst = 7'h06;
         4'h3:    hyst = 7'h08;
         4'h4:    hyst = 7'h08;
         4'h5:    hyst = 7'h10;
         4'h6:    hyst = 7'h18;
         4'h7:    hyst = 7'h20;
         4'h8:    hyst = 7'h28;
         4'h9:    hyst = 7'h2C;
         4'hA:    hyst = 7'h30;
         4'hB:    hyst = 7'h34;
         4'hC:    hyst = 7'h0C;
         4'hD:    hyst = 7'h14;
         4'hE:    hyst = 7'h1C;
         4'hF:    hyst = 7'h24;
         default: hyst = 7'h00;
      endcase
   end
endmodule : hyst_lookup

// File: logic/uart_flow_ctrl.sv
// One channel's flow control, half-duplex direction and feature registers
`include "uart_flow_cfg.svh"
module uart_flow_ctrl import uart_flow_pkg::*; #(
   parameter int CHAR_BITS = `CHAR_BITS_DEF
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // Register port
   input  wire reg_req_t   bus,
   output logic      [7:0] rdata,
   // Transmitter status
   input  wire tx_evt_t    tx_evt,
   input  wire logic       rts_gp_n,
   // Receive FIFO levels
   input  wire logic [6:0] rx_level,
   input  wire logic [6:0] rx_trig,
   input  wire logic [6:0] rx_next_up,
   input  wire logic [6:0] rx_next_dn,
   // Received characters in and to the FIFO
   input  wire rx_char_t   rx_in,
   output rx_char_t        rx_out,
   // Flow characters to the transmitter
   output logic            xmit_req,
   output logic      [7:0] xmit_char,
   input  wire logic       xmit_ack,
   // Line and control outputs
   output logic            rts_n,
   output logic            tx_irq,
   output logic            remote_paused,
   output logic      [3:0] ier_ext,
   output logic      [1:0] fcr_ext,
   output logic      [2:0] mcr_ext
);
   localparam int PAUSE_BITS = `PAUSE_CHARS * CHAR_BITS;

   // Counter width fixed at 5 bits
   generate
      if (CHAR_BITS < 7 || CHAR_BITS > 12) begin : g_bad
         $error("CHAR_BITS must be 7 to 12");
      end
   endgenerate

   logic [7:0] feature_control, enhanced_feature_control, res1, res2, pau1, pau2;
   logic [3:0] turn_dly;
   logic [1:0] stat;
   dir_state_t  dir, next_dir;
   flow_state_t fst, next_fst;
   logic [4:0] cnt, next_cnt;
   logic       kind_pause, second, local_paused, hw_stop;
   logic       seq_p, seq_r;

   // Field decode
   wire       enh      = enhanced_feature_control[`EF_ENH];
   wire       auto485  = feature_control[`FC_AUTO485];
   wire [1:0] rx_mode  = enhanced_feature_control[`EF_RX_LSB +: 2];
   wire [1:0] tx_mode  = enhanced_feature_control[`EF_TX_LSB +: 2];
   wire       table_d  = &feature_control[`FC_TABLE_LSB +: 2];
   wire [3:0] hyst_sel = feature_control[`FC_HYST_LSB +: 4];
   wire [6:0] hyst;

   hyst_lookup u_hyst (
      .code (hyst_sel),
      .hyst (hyst)
   );

   // Write decode
   wire wr_fc  = bus.wr && bus.addr == `OFS_FEATURE;
   wire wr_ef  = bus.wr && bus.addr == `OFS_ENHANCED;
   wire wr_r1  = bus.wr && bus.addr == `OFS_RESUME1;
   wire wr_r2  = bus.wr && bus.addr == `OFS_RESUME2;
   wire wr_p1  = bus.wr && bus.addr == `OFS_PAUSE1;
   wire wr_p2  = bus.wr && bus.addr == `OFS_PAUSE2;
   wire wr_dly = bus.wr && bus.addr == `OFS_TURN_DLY;
   // Locked fields ignore writes while enhanced enable is clear
   wire wr_ie  = bus.wr && bus.addr == `OFS_IRQ_EN && enh;
   wire wr_fcr = bus.wr && bus.addr == `OFS_FIFO_CTL && enh;
   wire wr_mcr = bus.wr && bus.addr == `OFS_MODEM_CTL && enh;
   wire wr_st  = bus.wr && bus.addr == `OFS_IRQ_STAT && enh;

   // Thresholds; a zero hysteresis code keeps the next-level behaviour
   wire use_h   = table_d && hyst_sel != 4'h0;
   wire [7:0] up_h = {1'b0, rx_trig} + {1'b0, hyst};
   wire [6:0] dn_h = (rx_trig > hyst) ? rx_trig - hyst : 7'h00;
   wire [7:0] upper = use_h ? up_h : {1'b0, rx_next_up};
   wire [6:0] lower = use_h ? dn_h : rx_next_dn;

   // Receive compares, bit 0 against the first flow character of a pair
   logic [1:0] hit_p, hit_r;
   generate
      for (genvar i = 0; i < 2; i++) begin : g_cmp
         assign hit_p[i] = rx_in.data == (i == 0 ? pau1 : pau2);
         assign hit_r[i] = rx_in.data == (i == 0 ? res1 : res2);
      end
   endgenerate

   wire seq_mode = rx_mode == 2'b11 && (tx_mode == 2'b00 ||
                                        tx_mode == 2'b11);
   wire pause_hit = rx_in.valid && (
        (rx_mode == 2'b01 && hit_p[1]) ||
        (rx_mode == 2'b10 && hit_p[0]) ||
        (rx_mode == 2'b11 && !seq_mode && |hit_p) ||
        (seq_mode && seq_p && hit_p[1]));
   wire resume_hit = rx_in.valid && (
        (rx_mode == 2'b01 && hit_r[1]) ||
        (rx_mode == 2'b10 && hit_r[0]) ||
        (rx_mode == 2'b11 && !seq_mode && |hit_r) ||
        (seq_mode && seq_r && hit_r[1]));
   wire special = rx_in.valid && enhanced_feature_control[`EF_SPECIAL] && hit_p[1];
   // Matched flow characters other than the first of a sequence pair never reach the FIFO
   wire store = rx_in.valid && !pause_hit && !resume_hit;

   // Control registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         feature_control     <= `RST_BYTE;
         enhanced_feature_control      <= `RST_BYTE;
         turn_dly <= `RST_NIBBLE;
      end else begin
         if (wr_fc)  feature_control     <= bus.wdata;
         if (wr_ef)  enhanced_feature_control      <= bus.wdata;
         if (wr_dly) turn_dly <= bus.wdata[7:4];
      end
   end

   // Flow characters
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         res1 <= `RST_BYTE;
         res2 <= `RST_BYTE;
         pau1 <= `RST_BYTE;
         pau2 <= `RST_BYTE;
      end else begin
         if (wr_r1) res1 <= bus.wdata;
         if (wr_r2) res2 <= bus.wdata;
         if (wr_p1) pau1 <= bus.wdata;
         if (wr_p2) pau2 <= bus.wdata;
      end
   end

   // Lockable enhanced fields, cleared by reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ier_ext <= 4'h0;
         fcr_ext <= 2'h0;
         mcr_ext <= 3'h0;
      end else begin
         if (wr_ie)  ier_ext <= bus.wdata[7:4];
         if (wr_fcr) fcr_ext <= bus.wdata[5:4];
         if (wr_mcr) mcr_ext <= bus.wdata[7:5];
      end
   end

   // Status flags: a hit in the clearing cycle survives the clear
   wire [1:0] st_set = {pause_hit, special};
   wire [1:0] st_clr = wr_st ? bus.wdata[5:4] : 2'b00;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) stat <= 2'b00;
      else       stat <= (stat & ~st_clr) | st_set;
   end

   // Read mux, answered one cycle after the strobe
   logic [7:0] rd_mux;
   always_comb begin
      case (bus.addr)
         `OFS_FEATURE:   rd_mux = feature_control;
         `OFS_ENHANCED:  rd_mux = enhanced_feature_control;
         `OFS_RESUME1:   rd_mux = res1;
         `OFS_RESUME2:   rd_mux = res2;
         `OFS_PAUSE1:    rd_mux = pau1;
         `OFS_PAUSE2:    rd_mux = pau2;
         `OFS_IRQ_EN:    rd_mux = {ier_ext, 4'h0};
         `OFS_FIFO_CTL:  rd_mux = {2'b00, fcr_ext, 4'h0};
         `OFS_MODEM_CTL: rd_mux = {mcr_ext, 5'h00};
         `OFS_IRQ_STAT:  rd_mux = {2'b00, stat, 4'h0};
         `OFS_STATE:     rd_mux = {4'h0, local_paused, hw_stop,
                                   remote_paused, rts_n};
         default:        rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)       rdata <= 8'h00;
      else if (bus.rd) rdata <= rd_mux;
   end

   // Receive path: sequence tracking, store and remote pause state
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         seq_p         <= 1'b0;
         seq_r         <= 1'b0;
         rx_out        <= '0;
         remote_paused <= 1'b0;
      end else begin
         if (rx_in.valid) begin
            seq_p <= hit_p[0];
            seq_r <= hit_r[0];
         end
         rx_out.valid <= store;
         rx_out.data  <= rx_in.data;
         if (rx_mode == 2'b00)  remote_paused <= 1'b0;
         else if (pause_hit)    remote_paused <= 1'b1;
         else if (resume_hit)   remote_paused <= 1'b0;
      end
   end

   // Hardware flow state, used when auto RTS is on
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)                           hw_stop <= 1'b0;
      else if ({1'b0, rx_level} >= upper)  hw_stop <= 1'b1;
      else if (rx_level < lower)           hw_stop <= 1'b0;
   end

   // Half-duplex direction; RTS rises the cycle after a load, so the
   // transmitter sees it high before it can shift a start bit
   always_comb begin
      next_dir = dir;
      next_cnt = cnt;
      case (dir)
         D_RX: if (tx_evt.thr_load) next_dir = D_TX;
         D_TX: begin
            if (tx_evt.tsr_empty && tx_evt.thr_empty &&
                !tx_evt.thr_load) begin
               next_cnt = 5'd0;
               next_dir = (turn_dly == 4'h0) ? D_RX : D_TURN;
            end
         end
         D_TURN: begin
            if (tx_evt.thr_load) next_dir = D_TX;
            else if (tx_evt.bit_tick) begin
               next_cnt = cnt + 5'd1;
               if (next_cnt == {1'b0, turn_dly}) next_dir = D_RX;
            end
         end
         default: next_dir = D_RX;
      endcase
      if (!auto485 && fst == F_IDLE) next_cnt = 5'd0;
   end

   wire next_rts_n = auto485 ? (next_dir != D_RX) :
                     enhanced_feature_control[`EF_AUTO_RTS] ? hw_stop : rts_gp_n;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dir    <= D_RX;
         rts_n  <= 1'b1;
         tx_irq <= 1'b0;
      end else begin
         dir    <= auto485 ? next_dir : D_RX;
         rts_n  <= next_rts_n;
         tx_irq <= auto485 ? tx_evt.tsr_empty
                           : tx_evt.thr_empty;
      end
   end

   // Transmit flow control sequencer; its own wait counter runs on ticks
   wire trig_hit  = rx_trig != 7'h00 && rx_level >= rx_trig;
   logic [4:0] wait_cnt, next_wait;
   logic next_kind, next_second, next_local;

   always_comb begin
      next_fst    = fst;
      next_wait   = wait_cnt;
      next_kind   = kind_pause;
      next_second = second;
      next_local  = local_paused;
      case (fst)
         F_IDLE: begin
            next_second = 1'b0;
            if (tx_mode != 2'b00 && !local_paused && trig_hit) begin
               next_fst  = F_WAIT;
               next_wait = 5'd0;
            end else if (tx_mode != 2'b00 && local_paused &&
                         rx_level < lower) begin
               next_fst  = F_SEND;
               next_kind = 1'b0;
            end
         end
         F_WAIT: begin
            if (tx_evt.bit_tick) next_wait = wait_cnt + 5'd1;
            if (next_wait == 5'(PAUSE_BITS)) begin
               next_fst  = F_SEND;
               next_kind = 1'b1;
            end
         end
         F_SEND: begin
            if (xmit_ack) begin
               if (tx_mode == 2'b11 && !second) next_second = 1'b1;
               else begin
                  next_fst   = F_IDLE;
                  next_local = kind_pause;
               end
            end
         end
         default: next_fst = F_IDLE;
      endcase
      if (tx_mode == 2'b00) begin
         next_fst   = F_IDLE;
         next_local = 1'b0;
      end
   end

   // Character choice: 01 second pair, 10 first pair, 11 first then second
   wire use_second = tx_mode == 2'b01 || next_second;
   wire [7:0] pick = next_kind ? (use_second ? pau2 : pau1)
                               : (use_second ? res2 : res1);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         fst          <= F_IDLE;
         cnt          <= 5'd0;
         wait_cnt     <= 5'd0;
         kind_pause   <= 1'b0;
         second       <= 1'b0;
         local_paused <= 1'b0;
         xmit_req     <= 1'b0;
         xmit_char    <= 8'h00;
      end else begin
         fst          <= next_fst;
         cnt          <= next_cnt;
         wait_cnt     <= next_wait;
         kind_pause   <= next_kind;
         second       <= next_second;
         local_paused <= next_local;
         xmit_req     <= next_fst == F_SEND;
         xmit_char    <= pick;
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_irq_holding: assert property (!auto485 ##1 !auto485
      |-> tx_irq == $past(tx_evt.thr_empty))
      else $error("tx irq not from holding empty");
   a_irq_shift: assert property (auto485 ##1 auto485
      |-> tx_irq == $past(tx_evt.tsr_empty))
      else $error("tx irq not from shift empty");
   a_rts_raise: assert property (auto485 && tx_evt.thr_load
      ##1 auto485 |-> rts_n)
      else $error("rts not high after load");
   a_rts_drop: assert property (auto485 && dir == D_TX &&
      turn_dly == 4'h0 && tx_evt.tsr_empty && tx_evt.thr_empty &&
      !tx_evt.thr_load ##1 auto485 |-> !rts_n)
      else $error("rts not low after last stop");
   a_turn_hold: assert property (auto485 && dir == D_TURN
      |-> rts_n && cnt < {1'b0, turn_dly})
      else $error("rts dropped inside turnaround");
   a_hyst_code: assert property (hyst_sel == 4'hC |-> hyst == 7'h0C)
      else $error("hysteresis code 1100 wrong");
   a_special_keep: assert property (rx_mode == 2'b10 && special
      |=> rx_out.valid && stat[`ST_SPECIAL])
      else $error("special char not stored");
   a_pause_drop: assert property (rx_mode == 2'b01 && special
      |=> !rx_out.valid && &stat)
      else $error("second pause char handling wrong");
   a_lock_hold: assert property (bus.wr &&
      bus.addr == `OFS_IRQ_EN && !enh |=> $stable(ier_ext))
      else $error("locked field changed");
   a_pause_char: assert property (xmit_req && tx_mode == 2'b10
      |-> xmit_char == (kind_pause ? pau1 : res1))
      else $error("wrong flow character");

   c_turnaround: cover property (dir == D_TURN ##[1:200] dir == D_RX);
   c_pause_sent: cover property (xmit_req && kind_pause && xmit_ack);
   c_dual_seq:   cover property (seq_mode && pause_hit);
endmodule : uart_flow_ctrl

// File: sim/remote_station.sv
// Remote station model that takes flow characters off the line
module remote_station import uart_flow_pkg::*; (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // Flow characters from the transmitter
   input  wire logic       xmit_req,
   input  wire logic [7:0] xmit_char,
   output logic            xmit_ack,
   // Answer late when set
   input  wire logic       slow
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] log_q [16];
   logic [7:0] n;
   logic [1:0] wait_c;

   // One ack per request; a slow station lets the request stand longer
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         xmit_ack <= 1'b0;
         n        <= 8'h00;
         wait_c   <= 2'h0;
      end else if (xmit_ack) begin
         xmit_ack <= 1'b0;
         wait_c   <= 2'h0;
      end else if (xmit_req) begin
         if (wait_c >= (slow ? 2'h3 : 2'h0)) begin
            xmit_ack       <= 1'b1;
            log_q[n[3:0]]  <= xmit_char; // Char taken while it stands
            n              <= n + 8'h01;
         end else begin
            wait_c <= wait_c + 2'h1;
         end
      end
   end
endmodule : remote_station

// File: sim/tb.sv
// Self-checking bench for the flow and half-duplex control block
`include "uart_flow_cfg.svh"
module tb import uart_flow_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, nrst, ld, te, se, tk, gp_n, slow;
   logic        xreq, xack, rts_n, tx_irq, paused;
   reg_req_t    bus;
   rx_char_t    rx_in, rx_out;
   logic [7:0]  rdata, xchar, e, ch, x, s, cur;
   logic [6:0]  lvl, trig, bnd;
   logic [3:0]  irq_enable_reg;
   logic [2:0]  modem_ctrl_reg;
   logic [1:0]  fifo_ctrl_reg, tc;
   int          error_cnt, n_tests, base;
   logic [6:0]  h_tab [16] = '{0, 4, 6, 8, 8, 16, 24, 32,
                                40, 44, 48, 52, 12, 20, 28, 36};
   logic [31:0] rx_tab [13] = '{32'h30A2_0510, 32'h3045_0500,
      32'h32A2_0510,
      32'h31A2_0630, 32'h31B2_0000, 32'h12A1_0220, 32'h12B1_0000,
      32'h13A1_0500, 32'h13A2_0220, 32'h13B1_0200, 32'h13B2_0000,
      32'h17A2_0220, 32'h17B1_0000};

   uart_flow_ctrl #(.CHAR_BITS(7)) DUT (
      .sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
      .tx_evt({ld, te, se, tk}), .rts_gp_n(gp_n), .rx_level(lvl),
      .rx_trig(trig), .rx_next_up(7'h3C), .rx_next_dn(7'h30),
      .rx_in(rx_in), .rx_out(rx_out), .xmit_req(xreq),
      .xmit_char(xchar), .xmit_ack(xack), .rts_n(rts_n),
      .tx_irq(tx_irq), .remote_paused(paused), .ier_ext(irq_enable_reg),
      .fcr_ext(fifo_ctrl_reg), .mcr_ext(modem_ctrl_reg));

   remote_station st (.sys_clk(sys_clk), .nrst(nrst), .xmit_req(xreq),
      .xmit_char(xchar), .xmit_ack(xack), .slow(slow));

   // Clock, and a bit tick every fourth cycle
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      tc <= tc + 2'h1;
      tk <= (tc == 2'h3);
   end

   task chk(input logic [7:0] g, input logic [7:0] ex);
      n_tests++;
      if (g !== ex) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, ex);
      end
   endtask : chk

   task cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : cyc

   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask : wr

   // Read data appears in the cycle after the strobe and holds until the next read
   task rd(input logic [3:0] a, input logic [7:0] ex);
      @(posedge sys_clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 chk(rdata, ex);
   endtask : rd

   task rxc(input logic [7:0] d);
      @(posedge sys_clk);
      rx_in <= '{1'b1, d};
      cyc(1);
      rx_in.valid <= 1'b0;
   endtask : rxc

   // Bounded wait for the station to have taken k more characters
   task wait_cnt(input int k);
      for (int i = 0; i < 300 && st.n != 8'(base + k); i++) cyc(1);
      chk(st.n, 8'(base + k));
   endtask : wait_cnt

   // Pause on trigger, then resume just below the lower level
   task flow(input logic [1:0] tx, input logic [1:0] tbl,
             input logic [3:0] hc);
      bnd = (tbl == 2'b11 && h_tab[hc] != 0) ? 7'h38 - h_tab[hc] : 7'h30;
      base = int'(st.n);
      wr(`OFS_ENHANCED, 8'h10);
      wr(`OFS_FEATURE, {tbl, 2'b00, hc});
      wr(`OFS_ENHANCED, {4'h1, tx, 2'b00});
      @(posedge sys_clk);
      lvl <= 7'h38;
      cyc(40);
      chk({7'h00, xreq}, 8'h00);
      wait_cnt(tx == 2'b11 ? 2 : 1);
      chk(st.log_q[base[3:0]], tx == 2'b01 ? 8'hA2 : 8'hA1);
      if (tx == 2'b11) chk(st.log_q[4'(base + 1)], 8'hA2);
      base = int'(st.n);
      lvl <= bnd;
      cyc(30);
      chk(st.n, base[7:0]);
      lvl <= bnd - 7'h01;
      wait_cnt(tx == 2'b11 ? 2 : 1);
      chk(st.log_q[base[3:0]], tx == 2'b01 ? 8'hB2 : 8'hB1);
      if (tx == 2'b11) chk(st.log_q[4'(base + 1)], 8'hB2);
      wr(`OFS_ENHANCED, 8'h10);
      lvl <= 7'h00;
   endtask : flow

   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   // Watchdog sized well above the expected run length
   initial begin
      repeat (30000) @(posedge sys_clk);
      error_cnt++;
      end_of_test();
   end

   initial begin
      nrst = 1'b0;
      bus = '0;
      rx_in = '0;
      {ld, te, se, gp_n, slow, tc, tk} = 7'b0001000;
      lvl = 7'h00;
      trig = 7'h38;
      cur = 8'h00;
      error_cnt = 0;
      n_tests = 0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      cyc(1);
      chk({4'h0, irq_enable_reg, 2'h0, fifo_ctrl_reg, modem_ctrl_reg}, 8'h00);
      rd(`OFS_ENHANCED, 8'h00);
      rd(4'hC, 8'h00);
      wr(`OFS_IRQ_EN, 8'hF0);
      cyc(1);
      chk({4'h0, irq_enable_reg}, 8'h00);
      wr(`OFS_ENHANCED, 8'h10);
      wr(`OFS_IRQ_EN, 8'hF0);
      wr(`OFS_FIFO_CTL, 8'h30);
      wr(`OFS_MODEM_CTL, 8'hE0);
      wr(`OFS_ENHANCED, 8'h00);
      wr(`OFS_IRQ_EN, 8'h00);
      wr(`OFS_FIFO_CTL, 8'h00);
      wr(`OFS_MODEM_CTL, 8'h00);
      cyc(1);
      chk({irq_enable_reg, 2'h0, fifo_ctrl_reg}, 8'hF3);
      chk({5'h00, modem_ctrl_reg}, 8'h07);
      rd(`OFS_IRQ_EN, 8'hF0);
      wr(`OFS_RESUME1, 8'hB1);
      wr(`OFS_RESUME2, 8'hB2);
      wr(`OFS_PAUSE1, 8'hA1);
      wr(`OFS_PAUSE2, 8'hA2);
      rd(`OFS_PAUSE2, 8'hA2);
      // Receive compare and special character, one row per case
      foreach (rx_tab[i]) begin
         {e, ch, x, s} = rx_tab[i];
         if (e !== cur) begin
            wr(`OFS_ENHANCED, 8'h10);
            wr(`OFS_ENHANCED, e);
            cur = e;
         end
         rxc(ch);
         if (x[2]) chk({7'h00, rx_out.valid}, {7'h00, x[0]});
         if (x[0]) chk(rx_out.data, ch);
         chk({7'h00, paused}, {7'h00, x[1]});
         rd(`OFS_IRQ_STAT, s);
         wr(`OFS_IRQ_STAT, 8'h30);
      end
      // Every hysteresis code in table D, other tables and codes after
      for (int c = 0; c < 16; c++) begin
         slow <= c[0];
         flow(2'b10, 2'b11, 4'(c));
      end
      flow(2'b01, 2'b00, 4'h5);
      flow(2'b11, 2'b01, 4'h0);
      flow(2'b10, 2'b10, 4'h0);
      // Half-duplex direction and transmit interrupt
      wr(`OFS_FEATURE, 8'h00);
      te <= 1'b1;
      cyc(3);
      chk({7'h00, tx_irq}, 8'h01);
      gp_n <= 1'b0;
      cyc(3);
      chk({7'h00, rts_n}, 8'h00);
      gp_n <= 1'b1;
      // Auto RTS: stop at the next upper level, go below the next lower
      wr(`OFS_ENHANCED, 8'h50);
      lvl <= 7'h3C;
      cyc(3);
      chk({7'h00, rts_n}, 8'h01);
      lvl <= 7'h2F;
      cyc(3);
      chk({7'h00, rts_n}, 8'h00);
      wr(`OFS_ENHANCED, 8'h10);
      lvl <= 7'h00;
      wr(`OFS_FEATURE, 8'h20);
      se <= 1'b1;
      cyc(3);
      chk({7'h00, rts_n}, 8'h00);
      {ld, te, se} <= 3'b100;
      cyc(1);
      ld <= 1'b0;
      chk({7'h00, rts_n}, 8'h01);
      te <= 1'b1;
      cyc(3);
      chk({6'h00, rts_n, tx_irq}, 8'h02);
      se <= 1'b1;
      cyc(3);
      chk({6'h00, rts_n, tx_irq}, 8'h01);
      wr(`OFS_TURN_DLY, 8'h30);
      rd(`OFS_TURN_DLY, 8'h00);
      {ld, te, se} <= 3'b100;
      cyc(1);
      ld <= 1'b0;
      {te, se} <= 2'b11;
      cyc(8);
      chk({7'h00, rts_n}, 8'h01);
      cyc(10);
      chk({7'h00, rts_n}, 8'h00);
      end_of_test();
   end
endmodule : tb
